// ===== hdl/crtht_pkg.sv
// shared constants for the crt horizontal / vertical timing block
package crtht_pkg;
  // io port bases, index and data ports sit one apart
  localparam logic [15:0] CRTHT_MONO_INDEX = 16'h03b4;
  localparam logic [15:0] CRTHT_MONO_DATA = 16'h03b5;
  localparam logic [15:0] CRTHT_COLOR_INDEX = 16'h03d4;
  localparam logic [15:0] CRTHT_COLOR_DATA = 16'h03d5;
  // register indices behind the data port
  localparam logic [6:0] CRTHT_IDX_HBLANK_END = 7'h03;
  localparam logic [6:0] CRTHT_IDX_HSYNC_START = 7'h04;
  localparam logic [6:0] CRTHT_IDX_HSYNC_END = 7'h05;
  localparam logic [6:0] CRTHT_IDX_VTOTAL_LOW = 7'h06;
  localparam logic [6:0] CRTHT_IDX_OVERFLOW = 7'h07;
  localparam logic [6:0] CRTHT_IDX_PRESET = 7'h08;
  // reset values
  localparam logic [7:0] CRTHT_RST_HBLANK_END = 8'h0080;
  localparam logic [7:0] CRTHT_RST_ZERO = 8'h0000;
  localparam logic [6:0] CRTHT_RST_INDEX = 7'h00;
  // field positions
  localparam int CRTHT_TOP_BIT = 7;
  localparam int CRTHT_SKEW_HI = 6;
  localparam int CRTHT_SKEW_LO = 5;
  localparam int CRTHT_FIELD5_HI = 4;
  localparam int CRTHT_OV_VT8 = 0;
  localparam int CRTHT_OV_VD8 = 1;
  localparam int CRTHT_OV_VR8 = 2;
  localparam int CRTHT_OV_VB8 = 3;
  localparam int CRTHT_OV_LC8 = 4;
  localparam int CRTHT_OV_VT9 = 5;
  localparam int CRTHT_OV_VD9 = 6;
  localparam int CRTHT_OV_VR9 = 7;
  // skew pipeline depth, largest two-bit skew
  localparam int CRTHT_SKEW_DEPTH = 3;
  // character clock divider, pixels per character
  localparam logic [3:0] CRTHT_CHAR_DIV = 4'h0008;
  localparam logic [3:0] CRTHT_ONE4 = 4'h0001;
  localparam logic [4:0] CRTHT_ONE5 = 5'h0001;
  localparam logic [4:0] CRTHT_ZERO5 = 5'h0000;
  localparam logic [7:0] CRTHT_ZERO8 = 8'h0000;
endpackage : crtht_pkg

// ===== hdl/crtht_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// register fields handed from the register file to the horizontal generator
interface crtht_cfg_if;
  logic char_en; // one-cycle character clock enable
  logic [7:0] hcount; // horizontal character counter
  logic [7:0] hblank_start; // blanking start position
  logic [5:0] hblank_end_value; // six-bit blanking end
  logic [7:0] hsync_start; // sync start position
  logic [4:0] hsync_end_value; // five-bit sync end
  logic [1:0] display_enable_skew; // de delay in characters
  logic [1:0] hsync_skew; // sync start delay in characters
  logic de_raw; // undelayed display enable
  modport regs (output char_en, hcount, hblank_start, hblank_end_value, hsync_start,
    hsync_end_value, display_enable_skew, hsync_skew, de_raw);
  modport gen (input char_en, hcount, hblank_start, hblank_end_value, hsync_start,
    hsync_end_value, display_enable_skew, hsync_skew, de_raw);
endinterface : crtht_cfg_if
`default_nettype wire

// ===== hdl/crtht_hgen.sv
`timescale 1ns/1ps
`default_nettype none
// horizontal blanking, sync and display enable with skew
module crtht_hgen
  import crtht_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  crtht_cfg_if.gen cfg, // fields from the register file
  output logic hblank, // horizontal blanking
  output logic hsync, // horizontal sync
  output logic display_enable // skewed display enable
);
  // all state in one struct
  typedef struct packed {
    logic [CRTHT_SKEW_DEPTH-1:0] de_pipe; // delayed display enable taps
    logic [CRTHT_SKEW_DEPTH-1:0] hs_pipe; // delayed sync start taps
    logic hblank; // blanking level
    logic hsync; // sync level
    logic de; // selected display enable
  } crtht_hgen_t;

  crtht_hgen_t st_q;
  crtht_hgen_t st_d;

  // pick tap by skew; zero skew takes the live value
  function automatic logic skew_tap(input logic live, input logic [CRTHT_SKEW_DEPTH-1:0] taps,
                                    input logic [1:0] skew);
    logic r;
    r = live;
    if (skew != 2'b00)
    begin
      r = taps[skew - 2'b01];
    end
    return r;
  endfunction : skew_tap

  // next state, everything advances on the character enable
  always_comb
  begin
    logic hs_start_now;
    logic de_now;
    hs_start_now = 1'b0;
    de_now = 1'b0;
    st_d = st_q;
    if (cfg.char_en)
    begin
      st_d.de_pipe = {st_q.de_pipe[CRTHT_SKEW_DEPTH-2:0], cfg.de_raw};
      st_d.hs_pipe = {st_q.hs_pipe[CRTHT_SKEW_DEPTH-2:0], cfg.hcount == cfg.hsync_start};
      if (cfg.hcount == cfg.hblank_start)
      begin
        st_d.hblank = 1'b1;
      end
      else if (cfg.hcount[5:0] == cfg.hblank_end_value)
      begin
        st_d.hblank = 1'b0;
      end
      hs_start_now = skew_tap(cfg.hcount == cfg.hsync_start, st_q.hs_pipe, cfg.hsync_skew);
      if (hs_start_now)
      begin
        st_d.hsync = 1'b1;
      end
      else if (cfg.hcount[4:0] == cfg.hsync_end_value)
      begin
        st_d.hsync = 1'b0;
      end
      de_now = skew_tap(cfg.de_raw, st_q.de_pipe, cfg.display_enable_skew);
      st_d.de = de_now;
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hblank = st_q.hblank;
  assign hsync = st_q.hsync;
  assign display_enable = st_q.de;
endmodule : crtht_hgen
`default_nettype wire

// ===== hdl/crtht_top.sv
// Overview of operation
// - blank-end top bit resets one, writable
// - de skew delays display enable
// - blank end joins five bits plus one
// - blank ends on six-bit count match
// - sync starts at start register match
// - sync skew delays sync start
// - sync ends on five-bit count match
// - vertical total assembled to eleven bits
// - overflow bits feed vertical high bits
// - byte panning added to memory address
// - line compare forces panning zero till vsync
// - row scan starts at preset after retrace
// - preset only for upper split region
// - row scan wraps at cell height
// - index port selects data port register
// - blank starts at blank start match
`timescale 1ns/1ps
`default_nettype none
module crtht_top
  import crtht_pkg::*;
(
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [15:0] io_addr, // io port address
  input wire logic io_wr, // io write strobe, one cycle
  input wire logic io_rd, // io read strobe, one cycle
  input wire logic [7:0] io_wdata, // io write data
  input wire logic io_color_sel, // address select, 1 = colour base
  output logic [7:0] io_rdata, // read data, one cycle after io_rd
  output logic io_rack, // read answered pulse
  input wire logic [7:0] hcount, // horizontal character counter
  input wire logic [7:0] hblank_start, // blank start register value
  input wire logic de_raw, // display enable before skew
  input wire logic scan_line_end, // pulse at end of each scan line
  input wire logic vsync_active, // vertical sync level
  input wire logic line_compare_hit, // pulse when line compare matches
  input wire logic split_enable, // split screen in effect
  input wire logic pixel_pan_compat, // attribute mode control bit 5
  input wire logic [4:0] cell_height, // cell height register field
  input wire logic vtotal_bit10, // total bit 10 from repaint control
  input wire logic [15:0] display_addr, // memory address before panning
  output logic char_en, // character clock enable pulse
  output logic hblank, // horizontal blanking
  output logic hsync, // horizontal sync
  output logic display_enable, // skewed display enable
  output logic [15:0] mem_addr, // panned memory address
  output logic [1:0] byte_panning, // effective byte panning
  output logic [4:0] row_scan, // row scan counter
  output logic [10:0] vertical_total, // eleven-bit vertical total
  output logic [1:0] vdisplay_end_high, // display end bits 9..8
  output logic [1:0] vsync_start_high, // sync start bits 9..8
  output logic vblank_start_high_bit, // blanking start bit 8
  output logic line_compare_high // line compare bit 8
);
  // all registered state of the top in one struct
  typedef struct packed {
    logic [6:0] index; // timing_index_register
    logic [7:0] hblank_end_skew; // blank end / de skew
    logic [7:0] hsync_start_position; // sync start
    logic [7:0] hsync_end_skew; // sync end / skew / blank end bit 5
    logic [7:0] vertical_total_low; // total low byte
    logic [7:0] vertical_overflow_bits; // vertical high bits
    logic [7:0] preset_row_scan_panning; // preset and panning
    logic [7:0] rdata; // read data
    logic rack; // read answered
    logic [3:0] div; // character clock divider
    logic char_en; // character enable
    logic pan_force; // panning forced to zero
    logic vsync_prev; // last vsync level for edges
    logic [4:0] row; // row scan counter
    logic lower_region; // below split line
    logic [15:0] addr; // panned address
    logic [10:0] vtotal; // assembled total
  } crtht_top_t;

  crtht_top_t st_q;
  crtht_top_t st_d;

  crtht_cfg_if cfg ();

  // port decode, base chosen by the address-select setting
  function automatic logic port_hit(input logic [15:0] a, input logic color,
                                    input logic data_port);
    logic [15:0] want;
    want = data_port ? (color ? CRTHT_COLOR_DATA : CRTHT_MONO_DATA)
                     : (color ? CRTHT_COLOR_INDEX : CRTHT_MONO_INDEX);
    return a == want;
  endfunction : port_hit

  // next state
  always_comb
  begin
    logic idx_hit;
    logic dat_hit;
    logic vsync_rise;
    logic vsync_fall;
    idx_hit = 1'b0;
    dat_hit = 1'b0;
    vsync_rise = 1'b0;
    vsync_fall = 1'b0;
    st_d = st_q;
    st_d.rack = 1'b0;
    idx_hit = port_hit(io_addr, io_color_sel, 1'b0);
    dat_hit = port_hit(io_addr, io_color_sel, 1'b1);

    if (io_wr && idx_hit)
    begin
      st_d.index = io_wdata[6:0];
    end
    else if (io_wr && dat_hit)
    begin
      case (st_q.index)
        CRTHT_IDX_HBLANK_END: st_d.hblank_end_skew = io_wdata;
        CRTHT_IDX_HSYNC_START: st_d.hsync_start_position = io_wdata;
        CRTHT_IDX_HSYNC_END: st_d.hsync_end_skew = io_wdata;
        CRTHT_IDX_VTOTAL_LOW: st_d.vertical_total_low = io_wdata;
        CRTHT_IDX_OVERFLOW: st_d.vertical_overflow_bits = io_wdata;
        CRTHT_IDX_PRESET: st_d.preset_row_scan_panning = io_wdata;
        // other indices belong to neighbouring parts
        default: st_d.index = st_q.index;
      endcase
    end

    // register read, answered next cycle
    if (io_rd && (idx_hit || dat_hit))
    begin
      st_d.rack = 1'b1;
      st_d.rdata = CRTHT_ZERO8;
      if (idx_hit)
      begin
        // reserved top bit reads zero
        st_d.rdata = {1'b0, st_q.index};
      end
      else
      begin
        case (st_q.index)
          CRTHT_IDX_HBLANK_END: st_d.rdata = st_q.hblank_end_skew;
          CRTHT_IDX_HSYNC_START: st_d.rdata = st_q.hsync_start_position;
          CRTHT_IDX_HSYNC_END: st_d.rdata = st_q.hsync_end_skew;
          CRTHT_IDX_VTOTAL_LOW: st_d.rdata = st_q.vertical_total_low;
          CRTHT_IDX_OVERFLOW: st_d.rdata = st_q.vertical_overflow_bits;
          CRTHT_IDX_PRESET: st_d.rdata = st_q.preset_row_scan_panning;
          // unmapped index reads zero
          default: st_d.rdata = CRTHT_ZERO8;
        endcase
      end
    end

    // character clock divider, one-cycle enable
    st_d.char_en = 1'b0;
    if (st_q.div == CRTHT_CHAR_DIV - CRTHT_ONE4)
    begin
      st_d.div = 4'h0000;
      st_d.char_en = 1'b1;
    end
    else
    begin
      st_d.div = st_q.div + CRTHT_ONE4;
    end

    // vsync edges
    st_d.vsync_prev = vsync_active;
    vsync_rise = vsync_active && !st_q.vsync_prev;
    vsync_fall = !vsync_active && st_q.vsync_prev;

    // forced zero until vsync start; set wins over clear
    if (line_compare_hit && pixel_pan_compat)
    begin
      st_d.pan_force = 1'b1;
    end
    else if (vsync_rise)
    begin
      st_d.pan_force = 1'b0;
    end

    st_d.addr = display_addr + {14'h0000,
      st_q.pan_force ? 2'b00 : st_q.preset_row_scan_panning[CRTHT_SKEW_HI:CRTHT_SKEW_LO]};

    // row scan counter
    if (vsync_fall)
    begin
      st_d.row = st_q.preset_row_scan_panning[CRTHT_FIELD5_HI:0];
      st_d.lower_region = 1'b0;
    end
    // lower split region starts at zero
    else if (line_compare_hit && split_enable)
    begin
      st_d.row = CRTHT_ZERO5;
      st_d.lower_region = 1'b1;
    end
    else if (scan_line_end)
    begin
      // clear at cell height, else count, wraps after 1Fh
      if (st_q.row == cell_height)
      begin
        st_d.row = CRTHT_ZERO5;
      end
      else
      begin
        st_d.row = st_q.row + CRTHT_ONE5;
      end
    end

    st_d.vtotal = {vtotal_bit10, st_q.vertical_overflow_bits[CRTHT_OV_VT9],
                   st_q.vertical_overflow_bits[CRTHT_OV_VT8], st_q.vertical_total_low};
  end

  // state register; undefined reset fields are cleared for determinism
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= '0;
      st_q.index <= CRTHT_RST_INDEX;
      // blank-end top bit resets to one
      st_q.hblank_end_skew <= CRTHT_RST_HBLANK_END;
      st_q.hsync_start_position <= CRTHT_RST_ZERO;
      st_q.hsync_end_skew <= CRTHT_RST_ZERO;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // fields to the generator
  assign cfg.char_en = st_q.char_en;
  assign cfg.hcount = hcount;
  assign cfg.hblank_start = hblank_start;
  // sixth bit from sync end register
  assign cfg.hblank_end_value = {st_q.hsync_end_skew[CRTHT_TOP_BIT],
                                 st_q.hblank_end_skew[CRTHT_FIELD5_HI:0]};
  assign cfg.hsync_start = st_q.hsync_start_position;
  assign cfg.hsync_end_value = st_q.hsync_end_skew[CRTHT_FIELD5_HI:0];
  assign cfg.display_enable_skew = st_q.hblank_end_skew[CRTHT_SKEW_HI:CRTHT_SKEW_LO];
  assign cfg.hsync_skew = st_q.hsync_end_skew[CRTHT_SKEW_HI:CRTHT_SKEW_LO];
  assign cfg.de_raw = de_raw;

  // horizontal generator, outputs are its flops
  crtht_hgen u_hgen (
    .clk_sys(clk_sys),
    .srst(srst),
    .cfg(cfg.gen),
    .hblank(hblank),
    .hsync(hsync),
    .display_enable(display_enable)
  );

  // outputs straight from state flops, except byte_panning, which is muxed to zero by pan_force
  assign io_rdata = st_q.rdata;
  assign io_rack = st_q.rack;
  assign char_en = st_q.char_en;
  assign mem_addr = st_q.addr;
  assign byte_panning = st_q.pan_force ? 2'b00
                      : st_q.preset_row_scan_panning[CRTHT_SKEW_HI:CRTHT_SKEW_LO];
  assign row_scan = st_q.row;
  assign vertical_total = st_q.vtotal;
  assign vdisplay_end_high = {st_q.vertical_overflow_bits[CRTHT_OV_VD9],
                              st_q.vertical_overflow_bits[CRTHT_OV_VD8]};
  assign vsync_start_high = {st_q.vertical_overflow_bits[CRTHT_OV_VR9],
                             st_q.vertical_overflow_bits[CRTHT_OV_VR8]};
  assign vblank_start_high_bit = st_q.vertical_overflow_bits[CRTHT_OV_VB8];
  assign line_compare_high = st_q.vertical_overflow_bits[CRTHT_OV_LC8];
endmodule : crtht_top
`default_nettype wire

// ===== tb/crtht_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module crtht_chk
  import crtht_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [15:0] io_addr, // io port address
  input wire logic io_wr, // io write strobe
  input wire logic io_rd, // io read strobe
  input wire logic [7:0] io_wdata, // io write data
  input wire logic io_color_sel, // base select
  input wire logic io_rack, // read answer
  input wire logic [7:0] hcount, // character counter
  input wire logic [7:0] hblank_start, // blank start value
  input wire logic scan_line_end, // line pulse
  input wire logic vsync_active, // vertical sync level
  input wire logic line_compare_hit, // line compare pulse
  input wire logic split_enable, // split screen
  input wire logic pixel_pan_compat, // panning compatibility
  input wire logic [4:0] cell_height, // cell height
  input wire logic vtotal_bit10, // total bit 10
  input wire logic [15:0] display_addr, // address before panning
  input wire logic char_en, // character enable
  input wire logic hblank, // blanking
  input wire logic hsync, // sync
  input wire logic [15:0] mem_addr, // panned address
  input wire logic [1:0] byte_panning, // effective panning
  input wire logic [4:0] row_scan, // row scan counter
  input wire logic [10:0] vertical_total, // vertical total
  input wire logic [1:0] vdisplay_end_high, // display end high bits
  input wire logic [1:0] vsync_start_high, // sync start high bits
  input wire logic vblank_start_high_bit, // blank start bit 8
  input wire logic line_compare_high // line compare bit 8
);
  logic [6:0] idx_q; // shadow index
  logic [7:0] r3_q, r4_q, r5_q, r6_q, r7_q, r8_q; // shadow registers
  logic dec_idx, dec_dat; // port decode at the selected base
  assign dec_idx = io_addr == (io_color_sel ? CRTHT_COLOR_INDEX : CRTHT_MONO_INDEX);
  assign dec_dat = io_addr == (io_color_sel ? CRTHT_COLOR_DATA : CRTHT_MONO_DATA);
  // shadow copy so compares can see the programmed positions
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      idx_q <= CRTHT_RST_INDEX;
      r3_q <= CRTHT_RST_HBLANK_END;
      {r4_q, r5_q, r6_q, r7_q, r8_q} <= 40'h00_0000_0000;
    end
    else if (io_wr && dec_idx)
      idx_q <= io_wdata[6:0];
    else if (io_wr && dec_dat)
    begin
      if (idx_q == CRTHT_IDX_HBLANK_END) r3_q <= io_wdata;
      if (idx_q == CRTHT_IDX_HSYNC_START) r4_q <= io_wdata;
      if (idx_q == CRTHT_IDX_HSYNC_END) r5_q <= io_wdata;
      if (idx_q == CRTHT_IDX_VTOTAL_LOW) r6_q <= io_wdata;
      if (idx_q == CRTHT_IDX_OVERFLOW) r7_q <= io_wdata;
      if (idx_q == CRTHT_IDX_PRESET) r8_q <= io_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RACK_DECODE: assert property (io_rd |=> io_rack == $past(dec_idx || dec_dat))
    else $error("read answer does not follow port decode");
  AST_BLANK_SET: assert property (char_en && hcount == hblank_start |=> hblank)
    else $error("blanking did not start");
  AST_BLANK_END: assert property (
    char_en && hcount != hblank_start && hcount[5:0] == {r5_q[7], r3_q[4:0]} |=> !hblank)
    else $error("blanking did not end");
  AST_SYNC_SET: assert property (
    char_en && hcount == r4_q && r5_q[6:5] == 2'b00 && hcount[4:0] != r5_q[4:0] |=> hsync)
    else $error("sync did not start");
  AST_VTOTAL: assert property (
    !$past(srst) |-> vertical_total ==
    {$past(vtotal_bit10), $past(r7_q[5]), $past(r7_q[0]), $past(r6_q)})
    else $error("vertical total wrong");
  AST_OV_HIGH: assert property (
    {vsync_start_high, vdisplay_end_high, vblank_start_high_bit, line_compare_high} ==
    {r7_q[7], r7_q[2], r7_q[6], r7_q[1], r7_q[3], r7_q[4]})
    else $error("overflow bits misplaced");
  AST_PAN_FORCE: assert property (
    line_compare_hit && pixel_pan_compat |=> byte_panning == 2'b00 [*3])
    else $error("panning not forced");
  AST_PAN_ADDR: assert property (
    !$past(srst) |-> mem_addr == $past(display_addr) + {14'h0000, $past(byte_panning)})
    else $error("panned address wrong");
  AST_ROW_PRESET: assert property ($fell(vsync_active) |=> row_scan == r8_q[4:0])
    else $error("row scan not preset");
  AST_ROW_SPLIT: assert property (
    line_compare_hit && split_enable && !$fell(vsync_active) |=> row_scan == 5'h00)
    else $error("lower region row not zero");
  AST_ROW_STEP: assert property (
    scan_line_end && !line_compare_hit && !$fell(vsync_active) |=> row_scan ==
    (($past(row_scan) == $past(cell_height)) ? 5'h00 : $past(row_scan) + 5'h01))
    else $error("row scan step wrong");
  // main scenarios reached
  cover property (io_rd && dec_dat && io_wr == 1'b0);
  cover property ($fell(vsync_active));
  cover property (line_compare_hit && pixel_pan_compat);
endmodule : crtht_chk
bind crtht_top crtht_chk u_chk (.*);
`default_nettype wire

// ===== tb/crtht_mon.sv
`timescale 1ns/1ps
`default_nettype none
// monitor side: measures sync, blank and enable per character
module crtht_mon
(
  input wire logic clk_sys, // system clock
  input wire logic char_en, // character strobe
  input wire logic [7:0] hcount, // beam position
  input wire logic hsync, // sync from the block
  input wire logic hblank, // blanking from the block
  input wire logic display_enable, // enable from the block
  output logic [7:0] hs_w, // last sync width in characters
  output logic [7:0] hs_pos, // first sync character
  output logic [7:0] hb_w, // last blank width in characters
  output logic [7:0] de_pos // first enabled character
);
  logic [7:0] hs_n = 8'h00; // running sync width
  logic [7:0] hb_n = 8'h00; // running blank width
  logic de_l = 1'b0; // enable at previous character
  // a monitor only sees whole characters, so count on the strobe
  always @(posedge clk_sys)
    if (char_en)
    begin
      hs_n <= hsync ? hs_n + 8'h01 : 8'h00;
      hb_n <= hblank ? hb_n + 8'h01 : 8'h00;
      de_l <= display_enable;
      if (hsync && hs_n == 8'h00) hs_pos <= hcount;
      if (!hsync && hs_n != 8'h00) hs_w <= hs_n;
      if (!hblank && hb_n != 8'h00) hb_w <= hb_n;
      if (display_enable && !de_l) de_pos <= hcount;
    end
endmodule : crtht_mon
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import crtht_pkg::*;
;
  logic clk_sys = 1'b0, srst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, io_color_sel = 1'b1;
  logic [15:0] io_addr = 16'h0000, display_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, hcount = 8'h00, hblank_start = 8'h10;
  logic scan_line_end = 1'b0, vsync_active = 1'b0, line_compare_hit = 1'b0;
  logic split_enable = 1'b0, pixel_pan_compat = 1'b0, vtotal_bit10 = 1'b1;
  logic [4:0] cell_height = 5'h05; // six lines per row
  wire logic de_raw; // first eight characters are shown
  logic [7:0] io_rdata, hs_w, hs_pos, hb_w, de_pos, ov;
  logic io_rack, char_en, hblank, hsync, display_enable, vblank_start_high_bit;
  logic line_compare_high;
  logic [15:0] mem_addr;
  logic [1:0] byte_panning, vdisplay_end_high, vsync_start_high, sk;
  logic [4:0] row_scan;
  logic [10:0] vertical_total;
  int errors = 0, compares = 0;
  assign de_raw = hcount < 8'h08;
  always #5 clk_sys = ~clk_sys;
  // beam position wraps at 64 characters to keep lines short
  always @(posedge clk_sys)
    if (char_en)
      hcount <= #1 (hcount == 8'h3f) ? 8'h00 : hcount + 8'h01;
  crtht_top dut (.clk_sys(clk_sys), .srst(srst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_color_sel(io_color_sel), .io_rdata(io_rdata),
    .io_rack(io_rack), .hcount(hcount), .hblank_start(hblank_start), .de_raw(de_raw),
    .scan_line_end(scan_line_end), .vsync_active(vsync_active),
    .line_compare_hit(line_compare_hit), .split_enable(split_enable),
    .pixel_pan_compat(pixel_pan_compat), .cell_height(cell_height),
    .vtotal_bit10(vtotal_bit10), .display_addr(display_addr), .char_en(char_en),
    .hblank(hblank), .hsync(hsync), .display_enable(display_enable), .mem_addr(mem_addr),
    .byte_panning(byte_panning), .row_scan(row_scan), .vertical_total(vertical_total),
    .vdisplay_end_high(vdisplay_end_high), .vsync_start_high(vsync_start_high),
    .vblank_start_high_bit(vblank_start_high_bit), .line_compare_high(line_compare_high));
  crtht_mon u_mon (.clk_sys(clk_sys), .char_en(char_en), .hcount(hcount), .hsync(hsync),
    .hblank(hblank), .display_enable(display_enable), .hs_w(hs_w), .hs_pos(hs_pos),
    .hb_w(hb_w), .de_pos(de_pos));
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // strobes rise one edge after the last fell, never in the same step
  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(posedge clk_sys);
    #1 io_wr = 1'b0;
  endtask : io_w
  task automatic io_r(input logic [15:0] a, input logic [7:0] exp, input logic ack);
    @(posedge clk_sys);
    #1 {io_addr, io_rd} = {a, 1'b1};
    @(posedge clk_sys);
    #1 io_rd = 1'b0;
    chk(io_rack, ack, "read answer");
    if (ack) chk(io_rdata, exp, "read data");
  endtask : io_r
  task automatic wreg(input logic [6:0] i, input logic [7:0] d);
    io_w(CRTHT_COLOR_INDEX, {1'b0, i});
    io_w(CRTHT_COLOR_DATA, d);
  endtask : wreg
  task automatic rreg(input logic [6:0] i, input logic [7:0] exp);
    io_w(CRTHT_COLOR_INDEX, {1'b0, i});
    io_r(CRTHT_COLOR_DATA, exp, 1'b1);
  endtask : rreg
  // ref, so the level reaches the block while the task runs
  task automatic pulse(ref logic sig, input int hold);
    @(posedge clk_sys);
    #1 sig = 1'b1;
    repeat (hold) @(posedge clk_sys);
    #1 sig = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : pulse
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 srst = 1'b0;
    rreg(CRTHT_IDX_HBLANK_END, 8'h80);
    rreg(CRTHT_IDX_PRESET, 8'h00);
    io_r(CRTHT_MONO_DATA, 8'h00, 1'b0);
    io_w(CRTHT_MONO_DATA, 8'h11);
    rreg(CRTHT_IDX_PRESET, 8'h00);
    rreg(7'h09, 8'h00);
    io_r(CRTHT_COLOR_INDEX, 8'h09, 1'b1);
    io_color_sel = 1'b0;
    io_r(CRTHT_MONO_INDEX, 8'h09, 1'b1);
    io_color_sel = 1'b1;
    for (int i = 3; i < 9; i++)
    begin
      wreg(7'(i), (i == 3) ? 8'h95 : 8'h25 + 8'(i));
      rreg(7'(i), (i == 3) ? 8'h95 : 8'h25 + 8'(i));
    end
    wreg(CRTHT_IDX_VTOTAL_LOW, 8'h5a);
    for (int k = 0; k < 2; k++)
    begin
      ov = k ? 8'h5a : 8'ha5;
      wreg(CRTHT_IDX_OVERFLOW, ov);
      repeat (3) @(posedge clk_sys);
      #1 chk(vertical_total, {vtotal_bit10, ov[5], ov[0], 8'h5a}, "total");
      chk({vsync_start_high, vdisplay_end_high, vblank_start_high_bit, line_compare_high},
        {ov[7], ov[2], ov[6], ov[1], ov[3], ov[4]}, "high bits");
    end
    // blank starts 0x10, far ahead of the first shown character
    wreg(CRTHT_IDX_HSYNC_START, 8'h12);
    for (int k = 0; k < 4; k++)
    begin
      sk = 2'(k);
      wreg(CRTHT_IDX_HBLANK_END, {1'b1, sk, 5'h18});
      wreg(CRTHT_IDX_HSYNC_END, {sk[0], sk, 5'h16});
      repeat (1100) @(posedge clk_sys);
      chk(hb_w, sk[0] ? 8'h28 : 8'h08, "blank width");
      chk(hs_w, 8'h04 - 8'(sk), "sync width");
      chk(hs_pos, 8'h13 + 8'(sk), "sync start");
      chk(de_pos, 8'h01 + 8'(sk), "enable start");
    end
    wreg(CRTHT_IDX_PRESET, 8'h03);
    pulse(vsync_active, 2);
    chk(row_scan, 5'h03, "preset row");
    for (int k = 0; k < 3; k++)
    begin
      pulse(scan_line_end, 1);
      chk(row_scan, (k == 2) ? 5'h00 : 5'h04 + 5'(k), "row step");
    end
    wreg(CRTHT_IDX_PRESET, 8'h1c);
    pulse(vsync_active, 2);
    for (int k = 0; k < 4; k++)
    begin
      pulse(scan_line_end, 1);
      chk(row_scan, (k == 3) ? 5'h00 : 5'h1d + 5'(k), "row past height");
    end
    split_enable = 1'b1;
    pulse(vsync_active, 2);
    pulse(line_compare_hit, 1);
    chk(row_scan, 5'h00, "lower region row");
    split_enable = 1'b0;
    display_addr = 16'h1000;
    for (int k = 0; k < 4; k++)
    begin
      wreg(CRTHT_IDX_PRESET, {1'b0, 2'(k), 5'h00});
      repeat (2) @(posedge clk_sys);
      #1 chk(mem_addr, 16'h1000 + 16'(k), "panned address");
    end
    pulse(line_compare_hit, 1);
    chk(byte_panning, 2'b11, "panning without compat");
    pixel_pan_compat = 1'b1;
    pulse(line_compare_hit, 1);
    chk(mem_addr, 16'h1000, "forced address");
    pulse(vsync_active, 1);
    chk(byte_panning, 2'b11, "panning after vsync");
    end_of_test();
  end
  // run needs about 4.6k cycles, allow plenty more
  initial
  begin
    #200000;
    errors++;
    $display("ERROR %0t: run did not finish", $time);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
